/* File: tt_pkg.sv */
// Shared constants, register map and field layouts of the second general-purpose timer
package tt_pkg;

  // Printed register indices; byte address on the bus is four times the index
  localparam logic [15:0] TT_IDX_COUNT  = 16'h4580;
  localparam logic [15:0] TT_IDX_THRESH = 16'h4586;
  localparam logic [15:0] TT_IDX_MATCHA = 16'h4588;
  localparam logic [15:0] TT_IDX_MATCHB = 16'h458A;
  localparam logic [15:0] TT_IDX_CONFIG = 16'h458C;
  localparam logic [15:0] TT_IDX_OUTA   = 16'h458F;
  localparam logic [15:0] TT_IDX_OUTB   = 16'h4590;
  localparam logic [15:0] TT_IDX_INA    = 16'h4592;
  localparam logic [15:0] TT_IDX_STATUS = 16'h4600;
  localparam logic [15:0] TT_IDX_CLEAR  = 16'h4601;
  localparam logic [15:0] TT_IDX_IRQEN  = 16'h4602;

  // Index field inside the byte address
  localparam int TT_IDX_LSB = 2;
  localparam int TT_IDX_MSB = 17;

  // Reset values
  localparam logic [15:0] TT_THRESH_RST = 16'hFFFF;
  localparam logic [15:0] TT_ZERO16     = 16'h0000;

  // Writable bit masks, reserved bits read as zero
  localparam logic [15:0] TT_CONFIG_MASK = 16'h1FFF;
  localparam logic [15:0] TT_OUTCFG_MASK = 16'h801F;
  localparam logic [15:0] TT_INCFG_MASK  = 16'h0160;

  // Status and interrupt bit positions
  localparam int TT_EV_WRAP   = 0;
  localparam int TT_EV_MATCHA = 1;
  localparam int TT_EV_MATCHB = 2;
  localparam int TT_EV_ZERO   = 3;
  localparam int TT_EV_THRESH = 4;
  localparam int TT_EV_CAPA   = 5;
  localparam int TT_EV_NUM    = 6;

  // Prescaler exponent limit and glitch filter depth
  localparam logic [3:0] TT_DIV_EXP_MAX = 4'h A;
  localparam int         TT_DIV_W       = 10;
  localparam int         TT_FILT_DEPTH  = 3;

  // AXI responses
  localparam logic [1:0] TT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TT_RESP_SLVERR = 2'h2;

  // Clock sources
  typedef enum logic [1:0] {
    TT_SRC_RC   = 2'h0,
    TT_SRC_32K  = 2'h1,
    TT_SRC_12M  = 2'h2,
    TT_SRC_GPIO = 2'h3
  } tt_src_t;

  // Capture edge selection
  typedef enum logic [1:0] {
    TT_CAP_OFF  = 2'h0,
    TT_CAP_RISE = 2'h1,
    TT_CAP_FALL = 2'h2,
    TT_CAP_BOTH = 2'h3
  } tt_cap_edge_t;

  // Match output waveform modes
  localparam logic [3:0] TT_MODE_LOW    = 4'h0;
  localparam logic [3:0] TT_MODE_SET    = 4'h1;
  localparam logic [3:0] TT_MODE_CLEAR  = 4'h2;
  localparam logic [3:0] TT_MODE_TOGGLE = 4'h3;
  localparam logic [3:0] TT_MODE_PWM_HI = 4'h4;
  localparam logic [3:0] TT_MODE_PWM_LO = 4'h5;

  // Configuration register layout
  typedef struct packed {
    logic [2:0] rsvd;
    logic       external_gate_select;
    logic       count_enable;
    logic       alternate_direction;
    logic       initial_direction_down;
    logic       single_run;
    logic [3:0] clock_divider_exponent;
    logic       clock_glitch_filter;
    logic       clock_falling_select;
    tt_src_t    clock_source_select;
  } tt_cfg_t;

  // Match output setup layout
  typedef struct packed {
    logic       match_output_enable;
    logic [9:0] rsvd;
    logic       match_output_invert;
    logic [3:0] match_output_mode;
  } tt_out_cfg_t;

  // Capture input setup layout
  typedef struct packed {
    logic [6:0]   rsvd_hi;
    logic         capture_input_filter;
    logic         rsvd_mid;
    tt_cap_edge_t capture_edge_select;
    logic [4:0]   rsvd_lo;
  } tt_in_cfg_t;

endpackage

/* File: tt_in_cond.sv */
// Pin conditioner: two-stage synchroniser, optional glitch filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tt_in_cond
  import tt_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  input  wire logic filt_en_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  typedef struct packed {
    logic                       meta;
    logic                       sync;
    logic [TT_FILT_DEPTH-2:0]   hist;
    logic                       level;
    logic                       rise;
    logic                       fall;
  } tt_cond_st_t;

  tt_cond_st_t s_q;
  tt_cond_st_t s_d;

  // Filter accepts a new level only after it is stable for the full depth
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pin_i;
    s_d.sync = s_q.meta;
    s_d.hist = {s_q.hist[TT_FILT_DEPTH-3:0], s_q.sync};
    if (!filt_en_i)
    begin
      s_d.level = s_q.sync;
    end
    else if (&{s_q.hist, s_q.sync} || ~|{s_q.hist, s_q.sync})
    begin
      s_d.level = s_q.sync;
    end
    s_d.rise = s_d.level & ~s_q.level;
    s_d.fall = ~s_d.level & s_q.level;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '0;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.level;
  assign rise_o  = s_q.rise;
  assign fall_o  = s_q.fall;

endmodule
`default_nettype wire

/* File: tt_match_out.sv */
// One match output: waveform mode, inversion and pin enable
`timescale 1ns/1ps
`default_nettype none
module tt_match_out
  import tt_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire tt_out_cfg_t  cfg_i,
  input  wire logic         match_i,
  input  wire logic         below_i,
  output logic              pin_o,
  output logic              oe_o
);

  typedef struct packed {
    logic wave;
    logic pin;
    logic oe;
  } tt_mo_st_t;

  tt_mo_st_t s_q;
  tt_mo_st_t s_d;

  // Waveform per mode; unknown mode codes hold the waveform low
  always_comb
  begin
    s_d = s_q;
    case (cfg_i.match_output_mode)
      TT_MODE_LOW:    s_d.wave = 1'b0;
      TT_MODE_SET:    s_d.wave = s_q.wave | match_i;
      TT_MODE_CLEAR:  s_d.wave = s_q.wave & ~match_i;
      TT_MODE_TOGGLE: s_d.wave = s_q.wave ^ match_i;
      TT_MODE_PWM_HI: s_d.wave = below_i;
      TT_MODE_PWM_LO: s_d.wave = ~below_i;
      default:        s_d.wave = 1'b0;
    endcase
    s_d.pin = s_d.wave ^ cfg_i.match_output_invert;
    s_d.oe  = cfg_i.match_output_enable;
  end

  // State register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q <= '0;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  assign pin_o = s_q.pin;
  assign oe_o  = s_q.oe;

endmodule
`default_nettype wire

/* File: tt_timer.sv */
// Second general-purpose timer: AXI4-Lite registers, counter, match outputs, capture event
`timescale 1ns/1ps
`default_nettype none
module tt_timer
  import tt_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        clk_rc_i,
  input  wire logic        clk_32k_i,
  input  wire logic        clk_12m_i,
  input  wire logic        clk_gpio_i,
  input  wire logic        gate_mask_pin_i,
  input  wire logic        capture_a_pin_i,
  output logic             match_a_o,
  output logic             match_a_oe_o,
  output logic             match_b_o,
  output logic             match_b_oe_o,
  output logic             irq_o
);
  import tt_pkg::*;

  typedef struct packed {
    logic                  aw_full;
    logic [15:0]           aw_idx;
    logic                  w_full;
    logic [15:0]           w_data;
    logic [1:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [15:0]           count;
    logic [15:0]           thresh;
    logic [15:0]           match_a;
    logic [15:0]           match_b;
    tt_cfg_t               cfg;
    tt_out_cfg_t           out_a;
    tt_out_cfg_t           out_b;
    tt_in_cfg_t            in_a;
    logic                  dir_down;
    logic                  done;
    logic                  en_prev;
    logic [TT_DIV_W-1:0]   div_cnt;
    logic [TT_EV_NUM-1:0]  status;
    logic [TT_EV_NUM-1:0]  irq_en;
    logic                  irq;
  } tt_st_t;

  tt_st_t s_q;
  tt_st_t s_d;

  // Register index from a byte address, shared by both access paths
  function automatic logic [15:0] addr_idx(input logic [31:0] a);
    addr_idx = a[TT_IDX_MSB:TT_IDX_LSB];
  endfunction

  // Byte-lane merge of a 16-bit register under a writable mask
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m       = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    merge16 = (old & ~m) | (nw & m);
  endfunction

  // Divider terminal count for exponent N, clamped to the largest valid N
  function automatic logic [TT_DIV_W-1:0] div_limit(input logic [3:0] n);
    logic [3:0] e;
    e         = (n > TT_DIV_EXP_MAX) ? TT_DIV_EXP_MAX : n;
    div_limit = TT_DIV_W'((11'h001 << e) - 11'h001);
  endfunction

  // Source clock pin selection ahead of the conditioner
  logic src_level;
  always_comb
  begin
    case (s_q.cfg.clock_source_select)
      TT_SRC_RC:   src_level = clk_rc_i;
      TT_SRC_32K:  src_level = clk_32k_i;
      TT_SRC_12M:  src_level = clk_12m_i;
      TT_SRC_GPIO: src_level = clk_gpio_i;
      default:     src_level = clk_rc_i;
    endcase
  end

  logic src_rise;
  logic src_fall;
  logic gate_level;
  logic cap_rise;
  logic cap_fall;

  // Timer clock conditioner; a mux glitch on source change is why asks to stop first
  tt_in_cond u_src_cond (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (src_level),
    .filt_en_i (s_q.cfg.clock_glitch_filter),
    .level_o   (),
    .rise_o    (src_rise),
    .fall_o    (src_fall)
  );

  // Gate mask pin, level only
  tt_in_cond u_gate_cond (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (gate_mask_pin_i),
    .filt_en_i (1'b0),
    .level_o   (gate_level),
    .rise_o    (),
    .fall_o    ()
  );

  // Capture A pin
  tt_in_cond u_cap_cond (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .pin_i     (capture_a_pin_i),
    .filt_en_i (s_q.in_a.capture_input_filter),
    .level_o   (),
    .rise_o    (cap_rise),
    .fall_o    (cap_fall)
  );

  // Match output units
  logic [1:0] match_hit;
  logic [1:0] match_below;
  logic [1:0] out_pin;
  logic [1:0] out_oe;
  tt_out_cfg_t out_cfg [2];
  assign out_cfg[0] = s_q.out_a;
  assign out_cfg[1] = s_q.out_b;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_out
      tt_match_out u_out (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .cfg_i   (out_cfg[g]),
        .match_i (match_hit[g]),
        .below_i (match_below[g]),
        .pin_o   (out_pin[g]),
        .oe_o    (out_oe[g])
      );
    end
  endgenerate

  assign match_below[0] = s_q.count < s_q.match_a;
  assign match_below[1] = s_q.count < s_q.match_b;

  // Event terms of the counting path
  logic                 run;
  logic                 edge_tick;
  logic                 tick;
  logic                 cap_event;
  logic [TT_EV_NUM-1:0] ev;

  always_comb
  begin
    edge_tick = s_q.cfg.clock_falling_select ? src_fall : src_rise;
    run       = s_q.cfg.count_enable & s_q.en_prev & ~s_q.done
                & (~s_q.cfg.external_gate_select | gate_level);
    tick      = run & edge_tick & (s_q.div_cnt == div_limit(s_q.cfg.clock_divider_exponent));
    case (s_q.in_a.capture_edge_select)
      TT_CAP_OFF:  cap_event = 1'b0;
      TT_CAP_RISE: cap_event = cap_rise;
      TT_CAP_FALL: cap_event = cap_fall;
      TT_CAP_BOTH: cap_event = cap_rise | cap_fall;
      default:     cap_event = 1'b0;
    endcase
  end

  // Counter, registers, bus slave and interrupt
  always_comb
  begin
    logic        do_wr;
    logic        hit_wr;
    logic        hit_rd;
    logic [15:0] rv;
    s_d    = s_q;
    do_wr  = 1'b0;
    hit_wr = 1'b1;
    hit_rd = 1'b1;
    rv     = TT_ZERO16;
    ev     = '0;

    // Enable edge reloads start direction and clears the single-run stop
    s_d.en_prev = s_q.cfg.count_enable;
    if (s_q.cfg.count_enable && !s_q.en_prev)
    begin
      s_d.dir_down = s_q.cfg.initial_direction_down;
      s_d.done     = 1'b0;
      s_d.div_cnt  = '0;
    end
    else if (run && edge_tick)
    begin
      s_d.div_cnt = tick ? '0 : TT_DIV_W'(s_q.div_cnt + 1'b1);
    end

    // Count step
    if (tick)
    begin
      if (!s_q.dir_down)
      begin
        if (s_q.count == s_q.thresh)
        begin
          if (s_q.cfg.alternate_direction)
          begin
            s_d.dir_down = 1'b1;
            s_d.count    = s_q.count - 16'h0001;
          end
          else
          begin
            ev[TT_EV_WRAP] = 1'b1;
            s_d.count      = TT_ZERO16;
            s_d.done       = s_q.cfg.single_run;
          end
        end
        else
        begin
          s_d.count = s_q.count + 16'h0001;
        end
      end
      else if (s_q.count == TT_ZERO16)
      begin
        ev[TT_EV_WRAP] = 1'b1;
        s_d.done       = s_q.cfg.single_run;
        if (s_q.cfg.alternate_direction)
        begin
          s_d.dir_down = 1'b0;
          s_d.count    = s_q.count + 16'h0001;
        end
        else
        begin
          s_d.count = s_q.thresh;
        end
      end
      else
      begin
        s_d.count = s_q.count - 16'h0001;
      end
      ev[TT_EV_ZERO]   = s_d.count == TT_ZERO16;
      ev[TT_EV_THRESH] = s_d.count == s_q.thresh;
      ev[TT_EV_MATCHA] = s_d.count == s_q.match_a;
      ev[TT_EV_MATCHB] = s_d.count == s_q.match_b;
    end
    ev[TT_EV_CAPA] = cap_event;
    match_hit      = {ev[TT_EV_MATCHB], ev[TT_EV_MATCHA]};

    // Write channels are held independently; the write happens once both are in
    if (s_axi_awvalid_i && !s_q.aw_full)
    begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx  = addr_idx(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && !s_q.w_full)
    begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata_i[15:0];
      s_d.w_strb = s_axi_wstrb_i[1:0];
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid)
    begin
      do_wr       = 1'b1;
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
    end
    if (s_q.bvalid && s_axi_bready_i)
    begin
      s_d.bvalid = 1'b0;
    end

    // Status: hardware set wins over a clear in the same cycle
    s_d.status = s_q.status;
    if (do_wr && s_q.aw_idx == TT_IDX_CLEAR && s_q.w_strb[0])
    begin
      s_d.status = s_q.status & ~s_q.w_data[TT_EV_NUM-1:0];
    end
    s_d.status = s_d.status | ev;

    // Register writes; software may change setup at any time, stopping first is its duty
    if (do_wr)
    begin
      case (s_q.aw_idx)
        TT_IDX_COUNT:
        begin
          s_d.count    = TT_ZERO16;
          s_d.dir_down = s_q.cfg.initial_direction_down;
          s_d.done     = 1'b0;
          s_d.div_cnt  = '0;
        end
        TT_IDX_THRESH: s_d.thresh  = merge16(s_q.thresh, s_q.w_data, s_q.w_strb, 16'hFFFF);
        TT_IDX_MATCHA: s_d.match_a = merge16(s_q.match_a, s_q.w_data, s_q.w_strb, 16'hFFFF);
        TT_IDX_MATCHB: s_d.match_b = merge16(s_q.match_b, s_q.w_data, s_q.w_strb, 16'hFFFF);
        TT_IDX_CONFIG:
          s_d.cfg   = tt_cfg_t'(merge16(s_q.cfg, s_q.w_data, s_q.w_strb, TT_CONFIG_MASK));
        TT_IDX_OUTA:
          s_d.out_a = tt_out_cfg_t'(merge16(s_q.out_a, s_q.w_data, s_q.w_strb, TT_OUTCFG_MASK));
        TT_IDX_OUTB:
          s_d.out_b = tt_out_cfg_t'(merge16(s_q.out_b, s_q.w_data, s_q.w_strb, TT_OUTCFG_MASK));
        TT_IDX_INA:
          s_d.in_a  = tt_in_cfg_t'(merge16(s_q.in_a, s_q.w_data, s_q.w_strb, TT_INCFG_MASK));
        TT_IDX_CLEAR:  hit_wr = 1'b1;
        TT_IDX_IRQEN:
          s_d.irq_en = s_q.w_strb[0] ? s_q.w_data[TT_EV_NUM-1:0] : s_q.irq_en;
        default:       hit_wr = 1'b0;
      endcase
      s_d.bresp = hit_wr ? TT_RESP_OKAY : TT_RESP_SLVERR;
    end

    // Read: one cycle after the address is taken
    case (addr_idx(s_axi_araddr_i))
      TT_IDX_COUNT:  rv = s_q.count;
      TT_IDX_THRESH: rv = s_q.thresh;
      TT_IDX_MATCHA: rv = s_q.match_a;
      TT_IDX_MATCHB: rv = s_q.match_b;
      TT_IDX_CONFIG: rv = s_q.cfg;
      TT_IDX_OUTA:   rv = s_q.out_a;
      TT_IDX_OUTB:   rv = s_q.out_b;
      TT_IDX_INA:    rv = s_q.in_a;
      TT_IDX_STATUS: rv = 16'(s_q.status);
      TT_IDX_CLEAR:  rv = TT_ZERO16;
      TT_IDX_IRQEN:  rv = 16'(s_q.irq_en);
      default:       hit_rd = 1'b0;
    endcase
    if (s_axi_arvalid_i && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = {16'h0000, rv};
      s_d.rresp  = hit_rd ? TT_RESP_OKAY : TT_RESP_SLVERR;
    end
    else if (s_q.rvalid && s_axi_rready_i)
    begin
      s_d.rvalid = 1'b0;
    end

    s_d.irq = |(s_d.status & s_d.irq_en);
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_q        <= '0;
      s_q.thresh <= TT_THRESH_RST;
    end
    else if (ce_i)
    begin
      s_q <= s_d;
    end
  end

  // Ready terms are flops: free holding slot means ready
  assign s_axi_awready_o = ~s_q.aw_full;
  assign s_axi_wready_o  = ~s_q.w_full;
  assign s_axi_bvalid_o  = s_q.bvalid;
  assign s_axi_bresp_o   = s_q.bresp;
  assign s_axi_arready_o = ~s_q.rvalid;
  assign s_axi_rvalid_o  = s_q.rvalid;
  assign s_axi_rdata_o   = s_q.rdata;
  assign s_axi_rresp_o   = s_q.rresp;
  assign match_a_o       = out_pin[0];
  assign match_a_oe_o    = out_oe[0];
  assign match_b_o       = out_pin[1];
  assign match_b_oe_o    = out_oe[1];
  assign irq_o           = s_q.irq;

endmodule
`default_nettype wire

/* File: tt_timer_props.sv */
// Bus answer and match pin enable checker of the timer
`timescale 1ns/1ps
`default_nettype none
module tt_timer_props
(
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        match_a_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Both halves of a write taken at one edge, and a read address taken
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  property p_wr_ans;
    s_wr_take |=> !s_axi_awready_o ##1 s_axi_bvalid_o;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_free;
    s_axi_bvalid_o |-> s_axi_awready_o && s_axi_wready_o;
  endproperty
  a_b_free: assert property (p_b_free) else $error("write slot not freed");
  property p_b_drop;
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer stuck");
  property p_rd_ans;
    s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_drop;
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer stuck");
  property p_ar_block;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_rd_hi;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
  // Pin enable only follows a register write
  property p_oe_wr;
    $rose(match_a_oe_o) |-> $past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2);
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("pin enable without write");
endmodule
bind tt_timer tt_timer_props tt_timer_props_i (.clock_i, .nrst_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .match_a_oe_o);
`default_nettype wire

/* File: tt_pin_model.sv */
// Pin side of the timer: free-running clock sources, gate and capture pins
`timescale 1ns/1ps
`default_nettype none
module tt_pin_model
(
  input  wire logic clock_i,
  input  wire logic gate_i,
  input  wire logic cap_i,
  output logic      clk_rc_o,
  output logic      clk_32k_o,
  output logic      clk_12m_o,
  output logic      clk_gpio_o,
  output logic      gate_o,
  output logic      cap_o
);
  logic [7:0] cnt_q = 8'h00;
  // Sources are scaled to a few system cycles so runs stay short
  always_ff @(posedge clock_i)
  begin
    cnt_q <= cnt_q + 8'h01;
  end
  // Oscillators run free; GPIO is the 12M source inverted, the other sources differ in rate
  assign clk_rc_o   = cnt_q[1];
  assign clk_32k_o  = cnt_q[3];
  assign clk_12m_o  = cnt_q[2];
  assign clk_gpio_o = ~cnt_q[2];
  assign gate_o     = gate_i;
  assign cap_o      = cap_i;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench of the timer: register bus, gating, sources, match pins, interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tt_pkg::*;
  logic        clock_i = 1'h0;
  logic        nrst_i = 1'h0;
  logic        aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic        gate = 1'h0, cap = 1'h0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, x = 32'hcbb7_905a;
  logic        aw_r, w_r, b_v, ar_r, r_v, irq, ma, maoe, mb, mboe;
  logic        c_rc, c_32, c_12, c_gp, gp, cp;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];
  int          num_errors = 0, n_tests = 0, cyc = 0;
  // Timer under test; clock enable and lane strobes held on
  tt_timer tt_timer_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'h1), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r), .clk_rc_i(c_rc), .clk_32k_i(c_32), .clk_12m_i(c_12),
    .clk_gpio_i(c_gp), .gate_mask_pin_i(gp), .capture_a_pin_i(cp), .match_a_o(ma),
    .match_a_oe_o(maoe), .match_b_o(mb), .match_b_oe_o(mboe), .irq_o(irq));
  tt_pin_model tt_pin_model_i (
    .clock_i(clock_i), .gate_i(gate), .cap_i(cap), .clk_rc_o(c_rc), .clk_32k_o(c_32),
    .clk_12m_o(c_12), .clk_gpio_o(c_gp), .gate_o(gp), .cap_o(cp));
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [33:0] ok(input logic [15:0] d);
    return {TT_RESP_OKAY, 16'h0000, d};
  endfunction
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Write with both halves offered together; upper data half is noise
  task automatic wr(input logic [15:0] i, input logic [15:0] d, input logic [1:0] r);
    @(posedge clock_i);
    wq.push_back(r);
    awa <= {14'h0, i, 2'h0};
    wd <= {x[31:16], d};
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    do
    begin
      @(posedge clock_i);
      if (aw_r) aw_v <= 1'h0;
      if (w_r) w_v <= 1'h0;
    end
    while (b_v !== 1'h1);
    b_r <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] i, input logic [33:0] e);
    @(posedge clock_i);
    rq.push_back(e);
    ara <= {14'h0, i, 2'h0};
    ar_v <= 1'h1;
    r_r <= 1'h1;
    do
    begin
      @(posedge clock_i);
      if (ar_r) ar_v <= 1'h0;
    end
    while (r_v !== 1'h1);
    r_r <= 1'h0;
  endtask
  // Oldest note against each bus answer; cycle ceiling cuts a hang
  always @(posedge clock_i)
  begin
    cyc++;
    if ((b_v & b_r) === 1'h1) chk({32'h0, bresp}, {32'h0, wq.pop_front()});
    if ((r_v & r_r) === 1'h1) chk({rresp, rdata}, rq.pop_front());
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'h1;
    rd(TT_IDX_THRESH, ok(TT_THRESH_RST));
    rd(TT_IDX_CONFIG, ok(16'h0000));
    rd(16'h4700, {TT_RESP_SLVERR, 32'h0});
    wr(16'h4700, x[15:0], TT_RESP_SLVERR);
    for (int k = 0; k < 4; k++)
    begin
      x = nxt(x);
      wr(k[0] ? TT_IDX_MATCHB : TT_IDX_MATCHA, x[15:0], TT_RESP_OKAY);
      rd(k[0] ? TT_IDX_MATCHB : TT_IDX_MATCHA, ok(x[15:0]));
      wr(TT_IDX_INA, {7'h0, k[0], 1'h0, k[1:0], 5'h0}, TT_RESP_OKAY);
      rd(TT_IDX_INA, ok({7'h0, k[0], 1'h0, k[1:0], 5'h0}));
    end
    // Settings written with counting off
    wr(TT_IDX_CONFIG, x[15:0] & 16'hf7ff, TT_RESP_OKAY);
    rd(TT_IDX_CONFIG, ok(x[15:0] & 16'h17ff));
    wr(TT_IDX_OUTB, x[31:16], TT_RESP_OKAY);
    rd(TT_IDX_OUTB, ok(x[31:16] & TT_OUTCFG_MASK));
    wr(TT_IDX_OUTA, 16'h8010, TT_RESP_OKAY);
    wr(TT_IDX_OUTB, 16'h8000, TT_RESP_OKAY);
    repeat (4) @(posedge clock_i);
    chk({30'h0, ma, maoe, mb, mboe}, 34'hd);
    wr(TT_IDX_OUTA, 16'h0010, TT_RESP_OKAY);
    repeat (4) @(posedge clock_i);
    chk({33'h0, maoe}, 34'h0);
    // Gate low blocks counting although enabled
    wr(TT_IDX_CONFIG, 16'h0000, TT_RESP_OKAY);
    wr(TT_IDX_THRESH, 16'h0003, TT_RESP_OKAY);
    wr(TT_IDX_IRQEN, 16'h0001, TT_RESP_OKAY);
    wr(TT_IDX_CLEAR, 16'h003f, TT_RESP_OKAY);
    wr(TT_IDX_COUNT, 16'h0000, TT_RESP_OKAY);
    wr(TT_IDX_CONFIG, 16'h1002, TT_RESP_OKAY);
    wr(TT_IDX_CONFIG, 16'h1802, TT_RESP_OKAY);
    repeat (100) @(posedge clock_i);
    rd(TT_IDX_COUNT, ok(16'h0000));
    // Each source drives a wrap; odd passes gate with the pin high
    for (int s = 0; s < 4; s++)
    begin
      wr(TT_IDX_CONFIG, 16'h0000, TT_RESP_OKAY);
      wr(TT_IDX_CLEAR, 16'h003f, TT_RESP_OKAY);
      chk({33'h0, irq}, 34'h0);
      gate <= s[0];
      wr(TT_IDX_CONFIG, {3'h0, s[0], 10'h0, s[1:0]}, TT_RESP_OKAY);
      wr(TT_IDX_CONFIG, {3'h0, s[0], 10'h200, s[1:0]}, TT_RESP_OKAY);
      repeat (200) @(posedge clock_i);
      chk({33'h0, irq}, 34'h1);
    end
    wr(TT_IDX_IRQEN, 16'h0000, TT_RESP_OKAY);
    chk({33'h0, irq}, 34'h0);
    wr(TT_IDX_CONFIG, 16'h0000, TT_RESP_OKAY);
    wr(TT_IDX_COUNT, 16'h0000, TT_RESP_OKAY);
    repeat (100) @(posedge clock_i);
    rd(TT_IDX_COUNT, ok(16'h0000));
    // Single runs from zero: down wraps to the threshold, alternate turns back at the threshold and stops at one
    for (int m = 0; m < 2; m++)
    begin
      wr(TT_IDX_CONFIG, m[0] ? 16'h0500 : 16'h0300, TT_RESP_OKAY);
      wr(TT_IDX_COUNT, 16'h0000, TT_RESP_OKAY);
      wr(TT_IDX_CONFIG, m[0] ? 16'h0d00 : 16'h0b00, TT_RESP_OKAY);
      repeat (100) @(posedge clock_i);
      rd(TT_IDX_COUNT, ok(m[0] ? 16'h0001 : 16'h0003));
    end
    // Rising capture edge raises its event
    wr(TT_IDX_INA, 16'h0020, TT_RESP_OKAY);
    wr(TT_IDX_CLEAR, 16'h003f, TT_RESP_OKAY);
    wr(TT_IDX_IRQEN, 16'h0020, TT_RESP_OKAY);
    cap <= 1'h1;
    repeat (12) @(posedge clock_i);
    chk({33'h0, irq}, 34'h1);
    finish_test();
  end
endmodule
`default_nettype wire
